/* File: logic/rsx_defs.svh */
`ifndef RSX_DEFS_SVH
`define RSX_DEFS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define RSX_NUM_VO        64
`define RSX_NUM_PAIRS     128
`define RSX_NUM_PREDEF    32
`define RSX_NUM_USER_MAX  96
`define RSX_NUM_POINTS    64
`define RSX_NUM_SRC       16
`define RSX_NUM_RI        32
`define RSX_NUM_CO        8
`define RSX_ID_CHARS      20
`define RSX_ID_W          160
`define RSX_HOLD_W        18
`define RSX_UPD_W         6
`define RSX_SRC_W         4
`define RSX_SEL_W         6
`define RSX_TICK_W        18

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RSX_UPD_MIN_S     1
`define RSX_UPD_MAX_S     60
`define RSX_UPD_DEFAULT_S 60
`define RSX_HOLD_MULT     3
`define RSX_MS_PER_S      1000
`define RSX_CLK_PERIOD_PS 4000
`define RSX_TICK_US       1000
`define RSX_TICK_CYCLES   ((`RSX_TICK_US * 1000000) / `RSX_CLK_PERIOD_PS)

// ---------------------------------------------------------------
// Bit pair encodings
// ---------------------------------------------------------------
`define RSX_PAIR_ON       2'h2
`define RSX_PAIR_OFF      2'h1
`define RSX_PAIR_IDLE     2'h0

`endif

/* File: logic/rsx_pkg.sv */
`include "rsx_defs.svh"

package rsx_pkg;

    typedef struct packed {
        logic [`RSX_ID_W-1:0]          origin_id;
        logic [`RSX_HOLD_W-1:0]        hold_ms;
        logic [2*`RSX_NUM_PAIRS-1:0]   pairs;
    } rsx_msg_type;

    typedef logic [`RSX_NUM_POINTS-1:0] rsx_points_type;

    // Unsupported user pairs go out idle
    function automatic logic [2*`RSX_NUM_PAIRS-1:0] rsx_encode(
        input rsx_points_type pts);
        logic [2*`RSX_NUM_PAIRS-1:0] p;
        p = '0;
        for (int i = 0; i < `RSX_NUM_POINTS; i++) begin
            p[2*i +: 2] = pts[i] ? `RSX_PAIR_ON : `RSX_PAIR_OFF;
        end
        return p;
    endfunction

    function automatic rsx_points_type rsx_decode(
        input logic [2*`RSX_NUM_PAIRS-1:0] pairs);
        rsx_points_type pts;
        pts = '0;
        for (int i = 0; i < `RSX_NUM_POINTS; i++) begin
            pts[i] = pairs[2*i+1];
        end
        return pts;
    endfunction

    function automatic logic [`RSX_HOLD_W-1:0] rsx_sec_to_ms(
        input logic [`RSX_UPD_W-1:0] s);
        return `RSX_HOLD_W'(s) * `RSX_HOLD_W'(`RSX_MS_PER_S);
    endfunction

endpackage

/* File: logic/rsx_source_slot.sv */
`timescale 1ns/1ps
`include "rsx_defs.svh"

module rsx_source_slot (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic                   tick,
    input  wire logic                   rx_valid,
    input  wire rsx_pkg::rsx_msg_type   rx_msg,
    input  wire logic [`RSX_ID_W-1:0]   source_id,
    output logic                        online,
    output rsx_pkg::rsx_points_type     points
);

    logic [`RSX_HOLD_W-1:0] hold_left;

    // -----------------------------------------------------------
    // Originator match and hold timer
    // -----------------------------------------------------------
    wire id_match = (rx_msg.origin_id == source_id);
    wire accept   = rx_valid & id_match;
    wire expire   = online & tick & (hold_left <= `RSX_HOLD_W'(1));

    // Reload beats expiry in the same cycle, so a late message
    // never sees a stale offline pulse
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            online    <= 1'b0;
            hold_left <= '0;
            points    <= '0;
        end else if (clk_en) begin
            if (accept) begin
                online    <= 1'b1;
                hold_left <= rx_msg.hold_ms;
                points    <= rsx_pkg::rsx_decode(rx_msg.pairs);
            end else begin
                if (tick && hold_left != '0) begin
                    hold_left <= hold_left - `RSX_HOLD_W'(1);
                end
                if (expire) begin
                    online <= 1'b0;
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    chk_foreign_ignored: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && rx_valid && !id_match |=> points == $past(points))
        else $error("points changed on foreign message");

    chk_accept_load: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && accept |=> online && hold_left == $past(rx_msg.hold_ms))
        else $error("accepted message did not restart hold timer");

    chk_expire_offline: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && expire && !accept |=> !online)
        else $error("source stayed online after hold expiry");

    cov_goes_offline: cover property (
        @(posedge mclk) disable iff (!rst_n)
        online ##1 !online);

endmodule

/* File: logic/rsx_top.sv */
`timescale 1ns/1ps
`include "rsx_defs.svh"


module rsx_top #(
    parameter int TICK_CYCLES = `RSX_TICK_CYCLES
) (
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic                        clk_en,
    input  wire logic                        eval_pass,
    input  wire logic [`RSX_NUM_VO-1:0]      vo_assigned,
    input  wire logic [`RSX_NUM_VO-1:0]      vo_equation,
    input  wire logic [`RSX_NUM_VO-1:0]      vo_event_en,
    output logic      [`RSX_NUM_VO-1:0]      virtual_out,
    output logic      [`RSX_NUM_VO-1:0]      vo_event,
    input  wire logic                        powerup_ok,
    input  wire rsx_pkg::rsx_points_type     tx_points,
    input  wire logic [`RSX_UPD_W-1:0]       update_interval_s,
    input  wire logic [`RSX_ID_W-1:0]        local_id,
    output logic                             tx_valid,
    output rsx_pkg::rsx_msg_type             tx_msg,
    input  wire logic                        rx_valid,
    input  wire rsx_pkg::rsx_msg_type        rx_msg,
    input  wire logic [`RSX_NUM_SRC-1:0][`RSX_ID_W-1:0]
                                             remote_source_identifier,
    output logic      [`RSX_NUM_SRC-1:0]     source_online,
    input  wire logic [`RSX_NUM_RI-1:0][`RSX_SRC_W-1:0]
                                             ri_source_sel,
    input  wire logic [`RSX_NUM_RI-1:0][`RSX_SEL_W-1:0]
                                             remote_input_pair_select,
    input  wire logic [`RSX_NUM_RI-1:0]      ri_fallback,
    output logic      [`RSX_NUM_RI-1:0]      remote_in,
    input  wire logic [`RSX_NUM_CO-1:0]      output_drive_operand,
    input  wire logic [`RSX_NUM_CO-1:0]      output_hold_operand,
    input  wire logic [`RSX_NUM_CO-1:0]      hold_is_current_on,
    input  wire logic [`RSX_NUM_CO-1:0]      trip_current_sense,
    output logic      [`RSX_NUM_CO-1:0]      trip_current_on_flag,
    output logic      [`RSX_NUM_CO-1:0]      trip_current_off_flag,
    output logic      [`RSX_NUM_CO-1:0]      contact_energise
);

    // -----------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // -----------------------------------------------------------
    // Millisecond tick
    // -----------------------------------------------------------
    logic [`RSX_TICK_W-1:0] tick_cnt;
    logic                   tick;

    wire tick_wrap = (tick_cnt == `RSX_TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else if (clk_en) begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + `RSX_TICK_W'(1);
            tick     <= tick_wrap;
        end
    end

    // -----------------------------------------------------------
    // Virtual outputs
    // -----------------------------------------------------------
    wire [`RSX_NUM_VO-1:0] next_vo = vo_assigned & vo_equation;
    wire [`RSX_NUM_VO-1:0] next_vo_event =
        (next_vo ^ virtual_out) & vo_event_en;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            virtual_out <= '0;
            vo_event    <= '0;
        end else if (clk_en) begin
            if (eval_pass) begin
                virtual_out <= next_vo;
                vo_event    <= next_vo_event;
            end else begin
                vo_event    <= '0;
            end
        end
    end

    // -----------------------------------------------------------
    // Transmitter
    // -----------------------------------------------------------
    logic                      pwr_q;
    rsx_pkg::rsx_points_type   last_points;
    logic [`RSX_HOLD_W-1:0]    ivl_left;

    // Out-of-range settings fall back to the default interval
    wire upd_ok = (update_interval_s >= `RSX_UPD_W'(`RSX_UPD_MIN_S))
               && (update_interval_s <= `RSX_UPD_W'(`RSX_UPD_MAX_S));
    wire [`RSX_UPD_W-1:0] upd_s = upd_ok ? update_interval_s
                                : `RSX_UPD_W'(`RSX_UPD_DEFAULT_S);
    wire [`RSX_HOLD_W-1:0] ivl_ms = rsx_pkg::rsx_sec_to_ms(upd_s);
    wire [`RSX_HOLD_W-1:0] hold_now =
        ivl_ms * `RSX_HOLD_W'(`RSX_HOLD_MULT);

    wire pwr_rise  = powerup_ok & ~pwr_q;
    wire pt_change = pwr_q & powerup_ok & (tx_points != last_points);
    wire ivl_due   = pwr_q & powerup_ok & tick
                   & (ivl_left <= `RSX_HOLD_W'(1));
    wire send      = pwr_rise | pt_change | ivl_due;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q       <= 1'b0;
            last_points <= '0;
            ivl_left    <= '0;
            tx_valid    <= 1'b0;
            tx_msg      <= '0;
        end else if (clk_en) begin
            pwr_q    <= powerup_ok;
            tx_valid <= send;
            if (send) begin
                last_points      <= tx_points;
                ivl_left         <= ivl_ms;
                tx_msg.origin_id <= local_id;
                tx_msg.hold_ms   <= hold_now;
                tx_msg.pairs     <= rsx_pkg::rsx_encode(tx_points);
            end else if (tick && ivl_left != '0) begin
                ivl_left <= ivl_left - `RSX_HOLD_W'(1);
            end
        end
    end

    // -----------------------------------------------------------
    // Remote sources
    // -----------------------------------------------------------
    rsx_pkg::rsx_points_type src_points [`RSX_NUM_SRC];

    for (genvar s = 0; s < `RSX_NUM_SRC; s++) begin : g_src
        rsx_source_slot u_slot (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .clk_en    (clk_en),
            .tick      (tick),
            .rx_valid  (rx_valid),
            .rx_msg    (rx_msg),
            .source_id (remote_source_identifier[s]),
            .online    (source_online[s]),
            .points    (src_points[s])
        );
    end

    // -----------------------------------------------------------
    // Remote inputs
    // -----------------------------------------------------------
    // Pair select 0..31 is predefined 1..32, 32..63 is user 1..32
    logic [`RSX_NUM_RI-1:0] next_remote_in;

    for (genvar g = 0; g < `RSX_NUM_RI; g++) begin : g_ri
        wire [`RSX_SRC_W-1:0] sel_src = ri_source_sel[g];
        wire [`RSX_SEL_W-1:0] sel_pair =
            remote_input_pair_select[g];
        wire                  src_up = source_online[sel_src];
        wire                  pair_bit = src_points[sel_src][sel_pair];
        assign next_remote_in[g] = src_up ? pair_bit
                                          : ri_fallback[g];
    end

    // Reset clears to zero only while rst_n is low; fallback appears on
    // the first enabled edge since every source starts offline
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remote_in <= '0;
        end else if (clk_en) begin
            remote_in <= next_remote_in;
        end
    end

    // -----------------------------------------------------------
    // Contact outputs with trip seal-in
    // -----------------------------------------------------------
    // The registered flag is used as hold, so sealing lags the
    // detector by one cycle; the drive operand covers that gap
    wire [`RSX_NUM_CO-1:0] hold_term =
        (hold_is_current_on & trip_current_on_flag)
        | (~hold_is_current_on & output_hold_operand);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trip_current_on_flag  <= '0;
            trip_current_off_flag <= '0;
            contact_energise      <= '0;
        end else if (clk_en) begin
            trip_current_on_flag  <= trip_current_sense;
            trip_current_off_flag <= ~trip_current_sense;
            contact_energise <= output_drive_operand | hold_term;
        end
    end

    // -----------------------------------------------------------
    // Checks
    // -----------------------------------------------------------
    chk_vo_unassigned: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && eval_pass |=>
            (virtual_out & ~$past(vo_assigned)) == '0)
        else $error("unassigned virtual output not zero");

    chk_vo_pass_eval: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && eval_pass |=>
            virtual_out == $past(vo_assigned & vo_equation))
        else $error("virtual outputs not recomputed on pass");

    chk_vo_event_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && eval_pass |=>
            vo_event == ((virtual_out ^ $past(virtual_out))
                         & $past(vo_event_en)))
        else $error("virtual output event mismatch");

    chk_tx_powerup: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && powerup_ok && !pwr_q |=> tx_valid)
        else $error("no message after power-up");

    chk_tx_change: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && pt_change |=>
            tx_valid && tx_msg.pairs == rsx_pkg::rsx_encode(
                $past(tx_points)))
        else $error("point change not sent at once");

    chk_tx_hold_time: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && send |=>
            tx_msg.hold_ms == $past(ivl_ms) * `RSX_HOLD_W'(3))
        else $error("hold time not three times interval");

    chk_tx_origin_id: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && send |=> tx_msg.origin_id == $past(local_id))
        else $error("local originator missing from message");

    chk_ri_fallback: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && rst_n && !source_online[ri_source_sel[0]] |=>
            remote_in[0] == $past(ri_fallback[0]))
        else $error("remote input ignored fallback while offline");

    chk_seal_in_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && hold_is_current_on[0] && trip_current_on_flag[0]
            |=> contact_energise[0])
        else $error("contact dropped while trip current flows");

    chk_ivl_reload: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && send |=> ivl_left == $past(ivl_ms))
        else $error("interval timer not reloaded on send");

    chk_vo_hold_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !(clk_en && eval_pass) |=> $stable(virtual_out))
        else $error("virtual outputs moved without a pass");

    chk_vo_event_quiet: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && !eval_pass |=> vo_event == '0)
        else $error("event raised without a pass");

    chk_vo_log_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en |=> (vo_event & ~$past(vo_event_en)) == '0)
        else $error("event raised with logging disabled");

    chk_tx_quiet_off: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && !powerup_ok |=> !tx_valid)
        else $error("message sent without power-up");

    chk_tx_default_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && send && !upd_ok |=>
            tx_msg.hold_ms == `RSX_HOLD_W'(`RSX_UPD_DEFAULT_S
                * `RSX_MS_PER_S * `RSX_HOLD_MULT))
        else $error("bad interval did not use the default");

    chk_tick_phase: assert property (
        @(posedge mclk) disable iff (!rst_n)
        tick |-> tick_cnt == '0)
        else $error("tick out of phase with its counter");

    chk_offline_on_tick: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && !tick |=> (~source_online & $past(source_online)) == '0)
        else $error("source dropped offline between ticks");

    chk_ri_follow: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && rst_n && source_online[ri_source_sel[0]] |=>
            remote_in[0] == $past(src_points[ri_source_sel[0]]
                                  [remote_input_pair_select[0]]))
        else $error("remote input did not follow its pair");

    chk_flag_pair: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && rst_n |=>
            (trip_current_on_flag ^ trip_current_off_flag) == '1)
        else $error("current flags not complementary");

    chk_drive_energise: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en |=> (contact_energise & $past(output_drive_operand))
            == $past(output_drive_operand))
        else $error("driven contact not energised");

    chk_seal_release: assert property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && !output_drive_operand[0] && hold_is_current_on[0]
            && !trip_current_on_flag[0] |=> !contact_energise[0])
        else $error("sealed contact held without current");

    cov_tx_on_change: cover property (
        @(posedge mclk) disable iff (!rst_n)
        clk_en && pt_change ##1 tx_valid);

    cov_ri_follows_src: cover property (
        @(posedge mclk) disable iff (!rst_n)
        source_online[ri_source_sel[0]] ##1 remote_in[0]);

    cov_seal_in: cover property (
        @(posedge mclk) disable iff (!rst_n)
        contact_energise[0] && !output_drive_operand[0]
            && trip_current_on_flag[0]);

endmodule

/* File: sim/rsx_peer.sv */
`timescale 1ns/1ps
`include "rsx_defs.svh"

// Remote device on the LAN: sends one frame per call
module rsx_peer (
    input  wire logic            mclk,
    output logic                 rx_valid,
    output rsx_pkg::rsx_msg_type rx_msg
);
    rsx_pkg::rsx_msg_type last;

    initial begin
        rx_valid = 1'b0;
        rx_msg   = '0;
        last     = '0;
    end

    task automatic send(input logic [`RSX_ID_W-1:0]       id,
                        input logic [`RSX_HOLD_W-1:0]     hold,
                        input logic [`RSX_NUM_POINTS-1:0] pts);
        int i;
        @(negedge mclk);
        last.origin_id = id;
        last.hold_ms   = hold;
        last.pairs     = '0;
        for (i = 0; i < `RSX_NUM_POINTS; i++) begin
            last.pairs[2*i +: 2] = pts[i] ? `RSX_PAIR_ON : `RSX_PAIR_OFF;
        end
        rx_msg   = last;
        rx_valid = 1'b1;
        @(negedge mclk);
        rx_valid = 1'b0;
        // Inverse of last frame, so a stale capture cannot pass
        rx_msg   = ~last;
    endtask
endmodule

/* File: sim/remote_state_exchange_test.sv */
`timescale 1ns/1ps
`include "rsx_defs.svh"

module remote_state_exchange_test;
    localparam int TICK  = 10;
    localparam int LIMIT = 40000;
    logic                 mclk, arst_n, clk_en, eval_pass, powerup_ok;
    logic [63:0]          vo_assigned, vo_equation, vo_event_en;
    logic [63:0]          virtual_out, vo_event, vo_m, ev;
    rsx_pkg::rsx_points_type tx_points, pts;
    logic [5:0]           update_interval_s;
    logic [159:0]         local_id;
    logic                 tx_valid, rx_valid;
    rsx_pkg::rsx_msg_type tx_msg, rx_msg;
    logic [15:0][159:0]   src_id;
    logic [15:0]          source_online, exp_online;
    logic [31:0][3:0]     ri_source_sel;
    logic [31:0][5:0]     pair_sel;
    logic [31:0]          ri_fallback, remote_in;
    logic [7:0]           drive, hold, hoc, sense, on_flag, off_flag, energise;
    logic [63:0]          pts_m [16];
    int                   n_mismatch, n_tests, cycles, seed, n, i;
    rsx_pkg::rsx_msg_type    tx_q [$];

    rsx_top #(.TICK_CYCLES(TICK)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
        .eval_pass(eval_pass), .vo_assigned(vo_assigned),
        .vo_equation(vo_equation), .vo_event_en(vo_event_en),
        .virtual_out(virtual_out), .vo_event(vo_event),
        .powerup_ok(powerup_ok), .tx_points(tx_points),
        .update_interval_s(update_interval_s), .local_id(local_id),
        .tx_valid(tx_valid), .tx_msg(tx_msg), .rx_valid(rx_valid),
        .rx_msg(rx_msg), .remote_source_identifier(src_id),
        .source_online(source_online), .ri_source_sel(ri_source_sel),
        .remote_input_pair_select(pair_sel), .ri_fallback(ri_fallback),
        .remote_in(remote_in), .output_drive_operand(drive),
        .output_hold_operand(hold), .hold_is_current_on(hoc),
        .trip_current_sense(sense), .trip_current_on_flag(on_flag),
        .trip_current_off_flag(off_flag), .contact_energise(energise));

    rsx_peer u_peer (.mclk(mclk), .rx_valid(rx_valid), .rx_msg(rx_msg));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // Reference model and checking
    // ---------------------------------------------------------------
    function automatic logic [255:0] enc(input logic [63:0] p);
        logic [255:0] r;
        r = '0;
        for (int k = 0; k < 64; k++) r[2*k +: 2] = p[k] ? 2'h2 : 2'h1;
        return r;
    endfunction

    // Out-of-range interval falls back to the 60 s default
    function automatic logic [17:0] hold_of(input logic [5:0] s);
        int v;
        v = (s >= 1 && s <= 60) ? s : 60;
        return 18'(v * 3000);
    endfunction

    // Captured when the stimulus is set, so later setting changes
    // cannot race the monitor
    function automatic rsx_pkg::rsx_msg_type exp_tx();
        return {local_id, hold_of(update_interval_s), enc(tx_points)};
    endfunction

    function automatic logic [31:0] ri_exp();
        logic [31:0] r;
        for (int k = 0; k < 32; k++) begin
            r[k] = exp_online[ri_source_sel[k]] ?
                   pts_m[ri_source_sel[k]][pair_sel[k]] : ri_fallback[k];
        end
        return r;
    endfunction

    task automatic check(input string name, input logic [433:0] seen,
                         input logic [433:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_tx(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
        end while (tx_valid !== 1'b1 && cnt < lim);
        check("tx_sent", tx_valid, 1);
    endtask

    always @(negedge mclk) begin
        if (tx_valid === 1'b1) begin
            if (tx_q.size() == 0) check("tx_unexpected", 1, 0);
            else check("tx_msg", tx_msg, tx_q.pop_front());
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        seed = 32'h0000_ba45;
        {arst_n, eval_pass, powerup_ok} = '0;
        clk_en = 1'b1;
        {vo_assigned, vo_equation, vo_event_en, vo_m} = '0;
        {tx_points, update_interval_s, drive, hold, hoc, sense} = '0;
        local_id = {$random(seed), $random(seed), $random(seed),
                    $random(seed), $random(seed)};
        for (i = 0; i < 16; i++) begin
            src_id[i] = {$random(seed), $random(seed), $random(seed),
                         $random(seed), $random(seed)};
            pts_m[i] = '0;
        end
        for (i = 0; i < 32; i++) begin
            ri_source_sel[i] = (i < 16) ? 4'h3 : 4'($random(seed));
            pair_sel[i] = 6'($random(seed));
        end
        ri_fallback = $random(seed);
        exp_online = '0;
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        check("online_reset", source_online, 0);
        check("remote_in_start", remote_in, ri_exp());

        for (i = 0; i < 6; i++) begin
            vo_assigned = {$random(seed), $random(seed)};
            vo_equation = {$random(seed), $random(seed)};
            vo_event_en = {$random(seed), $random(seed)};
            eval_pass = (i != 2);
            @(negedge mclk);
            ev = '0;
            if (i != 2) begin
                ev = ((vo_equation & vo_assigned) ^ vo_m) & vo_event_en;
                vo_m = vo_equation & vo_assigned;
            end
            check("virtual_out", virtual_out, vo_m);
            check("vo_event", vo_event, ev);
        end
        eval_pass = 1'b0;

        update_interval_s = 6'((($random(seed)) & 32'h0000_ffff) % 60 + 1);
        tx_points = {$random(seed), $random(seed)};
        tx_q.push_back(exp_tx());
        powerup_ok = 1'b1;
        wait_tx(5, n);
        update_interval_s = 6'h01;
        tx_points = {$random(seed), $random(seed)};
        tx_q.push_back(exp_tx());
        wait_tx(5, n);
        tx_q.push_back(exp_tx());
        wait_tx(10100, n);
        check("interval", n > 9960 && n < 10040, 1);
        update_interval_s = 6'h00;
        tx_points = ~tx_points;
        tx_q.push_back(exp_tx());
        wait_tx(5, n);
        @(negedge mclk);
        powerup_ok = 1'b0;
        tx_points = ~tx_points;
        repeat (20) @(negedge mclk);

        pts = {$random(seed), $random(seed)};
        u_peer.send(src_id[3], 18'h0_0005, pts);
        exp_online[3] = 1'b1;
        pts_m[3] = pts;
        check("online_accept", source_online, exp_online);
        @(negedge mclk);
        check("remote_in_rx", remote_in, ri_exp());
        u_peer.send(src_id[5] ^ 160'h1, 18'h0_0005, ~pts);
        @(negedge mclk);
        check("online_filter", source_online, exp_online);
        check("remote_in_filter", remote_in, ri_exp());
        repeat (20) @(negedge mclk);
        pts = {$random(seed), $random(seed)};
        u_peer.send(src_id[3], 18'h0_0005, pts);
        pts_m[3] = pts;
        @(negedge mclk);
        check("remote_in_update", remote_in, ri_exp());
        repeat (28) @(negedge mclk);
        check("online_restart", source_online, exp_online);
        n = 0;
        while (source_online[3] === 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        exp_online[3] = 1'b0;
        @(negedge mclk);
        check("online_expire", source_online, exp_online);
        check("remote_in_expire", remote_in, ri_exp());

        for (i = 0; i < 6; i++) begin
            {drive, hold, hoc, sense} = $random(seed);
            repeat (3) @(negedge mclk);
            check("on_flag", on_flag, sense);
            check("off_flag", off_flag, 8'(~sense));
            check("energise", energise,
                  drive | (hoc & sense) | (~hoc & hold));
        end
        {drive, hoc, sense, hold} = {8'hff, 8'hff, 8'hff, 8'h00};
        repeat (3) @(negedge mclk);
        drive = 8'h00;
        repeat (3) @(negedge mclk);
        check("seal_in", energise, 8'hff);
        sense = 8'h00;
        repeat (3) @(negedge mclk);
        check("seal_release", energise, 8'h00);
        complete_run();
    end
endmodule
